// [verilog/cfg_header_pkg.sv]
`default_nettype none
package cfg_header_pkg;
  localparam logic [7:0] OFS_LATENCY = 8'h0c;
  localparam logic [7:0] OFS_IO_BASE = 8'h10;
  localparam logic [7:0] OFS_MEM_BASE = 8'h14;
  localparam logic [7:0] OFS_SUBSYS = 8'h2c;
  localparam logic [7:0] OFS_ROM_BASE = 8'h30;
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_IRQ_CFG = 8'h3c;
  localparam logic [7:0] OFS_SCRATCH = 8'h40;
  localparam logic [31:0] LATENCY_WMASK = 32'h0000ffff;
  localparam logic [31:0] IO_WMASK = 32'hffffff00;
  localparam logic [31:0] IO_FLAG_SET = 32'h00000001;
  localparam logic [31:0] MEM_WMASK = 32'hfffffc00;
  localparam logic [31:0] ROM_WMASK = 32'hfffe0001;
  localparam logic [31:0] ROM_DECODE_MASK = 32'hfffc0000;
  localparam logic [31:0] IRQ_WMASK = 32'h000000ff;
  localparam logic [31:0] SCRATCH_WMASK = 32'h0000ff00;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [7:0] CAP_PTR_VALUE = 8'hc0;
  localparam logic [7:0] IRQ_PIN_VALUE = 8'h01;
  localparam int LAT_FIELD_LSB = 8;
  localparam int CLS_FIELD_LSB = 0;
  localparam int ROM_ENABLE_BIT = 0;
  localparam int SCRATCH_LSB = 8;
endpackage : cfg_header_pkg
`default_nettype wire

// [verilog/lat_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface lat_if;
  logic [7:0] latencyLimit;
  logic frameActive;
  logic gntGranted;
  logic expired;
  logic stopReq;
  modport ctrl (output latencyLimit, output frameActive,
    output gntGranted, input expired, input stopReq);
  modport timer (input latencyLimit, input frameActive,
    input gntGranted, output expired, output stopReq);
endinterface : lat_if
`default_nettype wire

// [verilog/latency_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module latency_timer (
  input wire logic clk,
  input wire logic rst_n,
  lat_if.timer lat
);
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  wire atLimit = (count_r >= lat.latencyLimit);

  // count restarts each time the master frame begins
  assign count_nxt = !lat.frameActive ? 8'h00 :
    (atLimit ? count_r : count_r + 8'h01); // [RULE1]
  assign lat.expired = lat.frameActive && atLimit; // [RULE1]
  // ends only once the arbiter has taken the grant away
  assign lat.stopReq = lat.expired && !lat.gntGranted; // [RULE2]

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= 8'h00;
    else
      count_r <= count_nxt;
  end

  chk_lat_count_up: assert property ( // [RULE1]
    @(posedge clk) disable iff (!rst_n)
    $rose(lat.frameActive) && lat.latencyLimit > 8'h02 |=>
    lat.frameActive [*2] or !lat.expired)
    else $error("latency timer expired too early");
  chk_lat_stop_gnt: assert property ( // [RULE2]
    @(posedge clk) disable iff (!rst_n)
    lat.stopReq |-> lat.frameActive && !lat.gntGranted
    && count_r >= lat.latencyLimit)
    else $error("master stop without expiry and lost grant");
endmodule : latency_timer
`default_nettype wire

// [verilog/pci_config_header_regs.sv]
// How it works
// [RULE1] count clocks in latency timer from frame
// [RULE2] expired and grant gone ends the transaction
// [RULE3] cache line size byte, writable, resets zero
// [RULE4] driver copies line size into bus mode
// [RULE5] io base: upper writable, bit0 reads one
// [RULE6] memory base: upper writable, low zero
// [RULE7] subsystem ids read-only, loaded from eeprom
// [RULE8] rom base low bits zero, upper writable
// [RULE9] all-ones write reads back sizing pattern
// [RULE10] rom decoded only with enable and memory
// [RULE11] software programs rom base before use
// [RULE12] capability pointer fixed at offset 34h
// [RULE13] max latency byte read-only from eeprom
// [RULE14] min grant byte read-only from eeprom
// [RULE15] interrupt pin byte fixed to first pin
// [RULE16] interrupt line byte just stores routing
// [RULE17] scratch byte survives software reset
// [RULE18] reserved and read-only bits ignore writes
`timescale 1ns/1ps
`default_nettype none
module pci_config_header_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfgReq,
  input wire logic cfgWrite,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWdata,
  output logic [31:0] cfgRdata_r,
  output logic cfgAck_r,
  input wire logic eeLoad,
  input wire logic [15:0] eeSubsysIdent,
  input wire logic [15:0] eeSubsysVendorIdent,
  input wire logic [7:0] eeMaxLatency,
  input wire logic [7:0] eeMinGrant,
  input wire logic memSpaceEnable,
  input wire logic masterFrame,
  input wire logic gntPin_n,
  input wire logic [31:0] romProbeAddr,
  output logic masterStop_r,
  output logic romDecodeEn_r,
  output logic romHit_r,
  output logic [31:0] ioBaseAddr_r,
  output logic [31:0] memBaseAddr_r,
  output logic [7:0] cacheLineWords_r
);
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
    input logic [31:0] wdata, input logic [3:0] be,
    input logic [31:0] wmask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = wdata[i*8 +: 8];
    mergeBytes = (res & wmask) | (old & ~wmask);
  endfunction : mergeBytes

  lat_if lat ();

  logic [31:0] latency_r;
  logic [31:0] ioBase_r;
  logic [31:0] memBase_r;
  logic [31:0] romBase_r;
  logic [31:0] irqCfg_r;
  logic [31:0] scratch_r;
  logic [15:0] subsysIdent_r;
  logic [15:0] subsysVendorIdent_r;
  logic [7:0] maxLatencyByte_r;
  logic [7:0] minGrantByte_r;
  logic gntMeta_r;
  logic gntSync_r;

  wire wrStrobe = cfgReq && cfgWrite;
  wire rdStrobe = cfgReq && !cfgWrite;
  wire wrLatency = wrStrobe && cfgAddr == cfg_header_pkg::OFS_LATENCY;
  wire wrIoBase = wrStrobe && cfgAddr == cfg_header_pkg::OFS_IO_BASE;
  wire wrMemBase = wrStrobe && cfgAddr == cfg_header_pkg::OFS_MEM_BASE;
  wire wrRomBase = wrStrobe && cfgAddr == cfg_header_pkg::OFS_ROM_BASE;
  wire wrIrqCfg = wrStrobe && cfgAddr == cfg_header_pkg::OFS_IRQ_CFG;
  wire wrScratch = wrStrobe && cfgAddr == cfg_header_pkg::OFS_SCRATCH;

  // write masks keep read-only and reserved bits at their value
  wire [31:0] latencyNxt = mergeBytes(latency_r, cfgWdata, cfgByteEn,
    cfg_header_pkg::LATENCY_WMASK); // [RULE3] [RULE18]
  wire [31:0] ioBaseNxt = mergeBytes(ioBase_r, cfgWdata, cfgByteEn,
    cfg_header_pkg::IO_WMASK); // [RULE5]
  wire [31:0] memBaseNxt = mergeBytes(memBase_r, cfgWdata, cfgByteEn,
    cfg_header_pkg::MEM_WMASK); // [RULE6]
  wire [31:0] romBaseNxt = mergeBytes(romBase_r, cfgWdata, cfgByteEn,
    cfg_header_pkg::ROM_WMASK); // [RULE8] [RULE9]
  wire [31:0] irqCfgNxt = mergeBytes(irqCfg_r, cfgWdata, cfgByteEn,
    cfg_header_pkg::IRQ_WMASK); // [RULE16]
  wire [31:0] scratchNxt = mergeBytes(scratch_r, cfgWdata, cfgByteEn,
    cfg_header_pkg::SCRATCH_WMASK); // [RULE17]

  // flag bit lives in the flop so the port stays a plain register
  wire [31:0] ioBaseView = ioBase_r; // [RULE5]
  wire [31:0] subsysView = {subsysIdent_r, subsysVendorIdent_r}; // [RULE7]
  wire [31:0] capView = {24'h000000,
    cfg_header_pkg::CAP_PTR_VALUE}; // [RULE12]
  wire [31:0] irqView = {maxLatencyByte_r, minGrantByte_r, // [RULE13] [RULE14]
    cfg_header_pkg::IRQ_PIN_VALUE, irqCfg_r[7:0]}; // [RULE15] [RULE16]

  // unmapped offsets read as zero
  wire [31:0] readMux =
    cfgAddr == cfg_header_pkg::OFS_LATENCY ? latency_r :
    cfgAddr == cfg_header_pkg::OFS_IO_BASE ? ioBaseView :
    cfgAddr == cfg_header_pkg::OFS_MEM_BASE ? memBase_r :
    cfgAddr == cfg_header_pkg::OFS_SUBSYS ? subsysView :
    cfgAddr == cfg_header_pkg::OFS_ROM_BASE ? romBase_r :
    cfgAddr == cfg_header_pkg::OFS_CAP_PTR ? capView :
    cfgAddr == cfg_header_pkg::OFS_IRQ_CFG ? irqView :
    cfgAddr == cfg_header_pkg::OFS_SCRATCH ? scratch_r :
    32'h00000000; // [RULE18]

  wire romEnable = romBase_r[cfg_header_pkg::ROM_ENABLE_BIT];
  // window compare uses the 256KB aperture only
  wire romMatch = ((romProbeAddr ^ romBase_r)
    & cfg_header_pkg::ROM_DECODE_MASK) == 32'h00000000; // [RULE8]
  wire romDecodeNxt = romEnable && memSpaceEnable; // [RULE10]

  assign lat.latencyLimit = latency_r[cfg_header_pkg::LAT_FIELD_LSB +: 8];
  assign lat.frameActive = masterFrame; // [RULE1]
  assign lat.gntGranted = !gntSync_r; // [RULE2]

  latency_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .lat(lat)
  );

  // grant pin is synchronised before the timer reads it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gntMeta_r <= 1'b1;
      gntSync_r <= 1'b1;
    end
    else
    begin
      gntMeta_r <= gntPin_n;
      gntSync_r <= gntMeta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latency_r <= cfg_header_pkg::REG_RESET; // [RULE3]
      ioBase_r <= cfg_header_pkg::IO_FLAG_SET; // [RULE5]
      memBase_r <= cfg_header_pkg::REG_RESET; // [RULE6]
      romBase_r <= cfg_header_pkg::REG_RESET;
    end
    else
    begin
      if (wrLatency)
        latency_r <= latencyNxt;
      if (wrIoBase)
        ioBase_r <= ioBaseNxt;
      if (wrMemBase)
        memBase_r <= memBaseNxt;
      if (wrRomBase)
        romBase_r <= romBaseNxt;
    end
  end

  // scratch only sees the hardware reset, never a software one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqCfg_r <= cfg_header_pkg::REG_RESET;
      scratch_r <= cfg_header_pkg::REG_RESET;
    end
    else
    begin
      if (wrIrqCfg)
        irqCfg_r <= irqCfgNxt;
      if (wrScratch)
        scratch_r <= scratchNxt; // [RULE17]
    end
  end

  // eeprom values are only replaced by the loader, not by writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      subsysIdent_r <= 16'h0000;
      subsysVendorIdent_r <= 16'h0000;
      maxLatencyByte_r <= 8'h00;
      minGrantByte_r <= 8'h00;
    end
    else if (eeLoad)
    begin
      subsysIdent_r <= eeSubsysIdent; // [RULE7]
      subsysVendorIdent_r <= eeSubsysVendorIdent; // [RULE7]
      maxLatencyByte_r <= eeMaxLatency; // [RULE13]
      minGrantByte_r <= eeMinGrant; // [RULE14]
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfgRdata_r <= 32'h00000000;
      cfgAck_r <= 1'b0;
    end
    else
    begin
      cfgAck_r <= cfgReq;
      if (rdStrobe)
        cfgRdata_r <= readMux;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      masterStop_r <= 1'b0;
      romDecodeEn_r <= 1'b0;
      romHit_r <= 1'b0;
    end
    else
    begin
      masterStop_r <= lat.stopReq; // [RULE2]
      romDecodeEn_r <= romDecodeNxt; // [RULE10]
      romHit_r <= romDecodeNxt && romMatch; // [RULE10]
    end
  end

  assign ioBaseAddr_r = ioBaseView;
  assign memBaseAddr_r = memBase_r;
  assign cacheLineWords_r = latency_r[cfg_header_pkg::CLS_FIELD_LSB +: 8];

  chk_cls_after_reset: assert property ( // [RULE3]
    @(posedge clk)
    $rose(rst_n) |-> cacheLineWords_r == 8'h00)
    else $error("cache line size not zero after reset");
  chk_cls_write_back: assert property ( // [RULE3]
    @(posedge clk) disable iff (!rst_n)
    wrLatency && cfgByteEn[0] |=> cacheLineWords_r == $past(cfgWdata[7:0]))
    else $error("cache line size write lost");
  chk_io_space_flag: assert property ( // [RULE5]
    @(posedge clk) disable iff (!rst_n)
    rdStrobe && cfgAddr == cfg_header_pkg::OFS_IO_BASE
    |=> cfgRdata_r[7:0] == 8'h01)
    else $error("io base low byte wrong");
  chk_io_flag_out: assert property ( // [RULE5]
    @(posedge clk) disable iff (!rst_n)
    ioBaseAddr_r[7:0] == 8'h01)
    else $error("io base port low byte wrong");
  chk_mem_low_zero: assert property ( // [RULE6]
    @(posedge clk) disable iff (!rst_n)
    rdStrobe && cfgAddr == cfg_header_pkg::OFS_MEM_BASE
    |=> cfgRdata_r[9:0] == 10'h000)
    else $error("memory base low bits not zero");
  chk_mem_low_keep: assert property ( // [RULE6]
    @(posedge clk) disable iff (!rst_n)
    wrMemBase |=> memBaseAddr_r[9:0] == 10'h000)
    else $error("memory base low bits written");
  chk_subsys_load: assert property ( // [RULE7]
    @(posedge clk) disable iff (!rst_n)
    eeLoad |=> subsysView == $past({eeSubsysIdent, eeSubsysVendorIdent}))
    else $error("subsystem identifiers not loaded");
  chk_ee_grant_load: assert property ( // [RULE13] [RULE14]
    @(posedge clk) disable iff (!rst_n)
    eeLoad |=> irqView[31:16] == $past({eeMaxLatency, eeMinGrant}))
    else $error("latency and grant bytes not loaded");
  chk_rom_sizing: assert property ( // [RULE9]
    @(posedge clk) disable iff (!rst_n)
    wrRomBase && cfgByteEn == 4'hf && cfgWdata == 32'hffffffff
    |=> romBase_r == 32'hfffe0001)
    else $error("rom sizing pattern wrong");
  chk_rom_decode_gate: assert property ( // [RULE10]
    @(posedge clk) disable iff (!rst_n)
    romHit_r |-> $past(romBase_r[0]) && $past(memSpaceEnable))
    else $error("rom decoded while disabled");
  chk_master_stop_gnt: assert property ( // [RULE2]
    @(posedge clk) disable iff (!rst_n)
    masterStop_r |-> $past(masterFrame) && $past(gntPin_n, 3))
    else $error("master stop while granted or idle");
  chk_cap_pointer: assert property ( // [RULE12]
    @(posedge clk) disable iff (!rst_n)
    rdStrobe && cfgAddr == cfg_header_pkg::OFS_CAP_PTR
    |=> cfgRdata_r == 32'h000000c0)
    else $error("capability pointer wrong");
  chk_irq_pin_code: assert property ( // [RULE15]
    @(posedge clk) disable iff (!rst_n)
    rdStrobe && cfgAddr == cfg_header_pkg::OFS_IRQ_CFG
    |=> cfgRdata_r[15:8] == 8'h01)
    else $error("interrupt pin byte wrong");
  chk_irq_line_keep: assert property ( // [RULE16]
    @(posedge clk) disable iff (!rst_n)
    wrIrqCfg && cfgByteEn[0] |=> irqCfg_r[7:0] == $past(cfgWdata[7:0]))
    else $error("interrupt line write lost");
  chk_scratch_keep: assert property ( // [RULE17]
    @(posedge clk) disable iff (!rst_n)
    !wrScratch |=> scratch_r == $past(scratch_r))
    else $error("scratch changed without a write");
  chk_unmapped_zero: assert property ( // [RULE18]
    @(posedge clk) disable iff (!rst_n)
    rdStrobe && cfgAddr == 8'h44 |=> cfgRdata_r == 32'h00000000)
    else $error("unmapped read not zero");
endmodule : pci_config_header_regs
`default_nettype wire

// [tb/cfg_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input wire logic clk,
  input wire logic cfgAck_r,
  input wire logic [31:0] cfgRdata_r,
  output logic cfgReq,
  output logic cfgWrite,
  output logic [7:0] cfgAddr,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWdata
);
  initial
  begin
    cfgReq = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 8'h00;
    cfgByteEn = 4'h0;
    cfgWdata = 32'h00000000;
  end
  // one request pulse; qualifiers held until the answer is seen
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] wd,
    output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h00000000;
    @(negedge clk);
    cfgReq = 1'b1;
    cfgWrite = wr;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWdata = wd;
    @(negedge clk);
    cfgReq = 1'b0;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (cfgAck_r === 1'b1)
      begin
        ok = 1'b1;
        rd = cfgRdata_r;
      end
      else
        @(negedge clk);
    end
    // released lines flip so a stale value cannot look right
    cfgAddr = ~cfgAddr;
    cfgWdata = ~cfgWdata;
    cfgWrite = ~cfgWrite;
  endtask : xfer
endmodule : cfg_host_model
`default_nettype wire

// [tb/pci_config_header_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module pci_config_header_regs_test;
  typedef struct {logic [7:0] a; logic [3:0] be; logic [31:0] wd;
    logic [31:0] ex;} row_t;
  logic clk, rst_n, cfgReq, cfgWrite, cfgAck_r, eeLoad, memSpaceEnable;
  logic masterFrame, gntPin_n, masterStop_r, romDecodeEn_r, romHit_r;
  logic [7:0] cfgAddr, cacheLineWords_r, eeMaxLatency, eeMinGrant;
  logic [3:0] cfgByteEn;
  logic [15:0] eeSubsysIdent, eeSubsysVendorIdent;
  logic [31:0] cfgWdata, cfgRdata_r, romProbeAddr, ioBaseAddr_r;
  logic [31:0] memBaseAddr_r, rd;
  int nErrors = 0;
  int nTests = 0;
  int cycles = 0;
  // write all ones (or a pattern), read back, expect masked result
  row_t rows [11] = '{
    '{8'h10, 4'hf, 32'hffffffff, 32'hffffff01},
    '{8'h14, 4'hf, 32'hffffffff, 32'hfffffc00},
    '{8'h30, 4'hf, 32'hffffffff, 32'hfffe0001},
    '{8'h3c, 4'hf, 32'hffffffff, 32'h5a3c01ff},
    '{8'h40, 4'hf, 32'hffffffff, 32'h0000ff00},
    '{8'h40, 4'h1, 32'h00000000, 32'h0000ff00},
    '{8'h0c, 4'hf, 32'hffffffff, 32'h0000ffff},
    '{8'h2c, 4'hf, 32'hffffffff, 32'h1234abcd},
    '{8'h34, 4'hf, 32'hffffffff, 32'h000000c0},
    '{8'h44, 4'hf, 32'hffffffff, 32'h00000000},
    '{8'h0c, 4'h3, 32'h00000308, 32'h00000308}
  };
  pci_config_header_regs uut (.clk(clk), .rst_n(rst_n), .cfgReq(cfgReq),
    .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
    .cfgWdata(cfgWdata), .cfgRdata_r(cfgRdata_r), .cfgAck_r(cfgAck_r),
    .eeLoad(eeLoad), .eeSubsysIdent(eeSubsysIdent),
    .eeSubsysVendorIdent(eeSubsysVendorIdent), .eeMaxLatency(eeMaxLatency),
    .eeMinGrant(eeMinGrant), .memSpaceEnable(memSpaceEnable),
    .masterFrame(masterFrame), .gntPin_n(gntPin_n),
    .romProbeAddr(romProbeAddr), .masterStop_r(masterStop_r),
    .romDecodeEn_r(romDecodeEn_r), .romHit_r(romHit_r),
    .ioBaseAddr_r(ioBaseAddr_r), .memBaseAddr_r(memBaseAddr_r),
    .cacheLineWords_r(cacheLineWords_r));
  cfg_host_model host (.clk(clk), .cfgAck_r(cfgAck_r),
    .cfgRdata_r(cfgRdata_r), .cfgReq(cfgReq), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      nErrors++;
      close_out();
    end
  end
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e)
    begin
      nErrors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk32
  task automatic chk1(input logic g, input logic e);
    nTests++;
    if (g !== e)
    begin
      nErrors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk1
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] wd, output logic [31:0] d);
    logic ok;
    host.xfer(wr, a, be, wd, d, ok);
    chk1(ok, 1'b1);
  endtask : bus
  task automatic close_out();
    $display("errors=%0d tests=%0d", nErrors, nTests);
    if (nErrors == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  initial
  begin
    rst_n = 1'b0;
    eeLoad = 1'b0;
    eeSubsysIdent = 16'h1234;
    eeSubsysVendorIdent = 16'habcd;
    eeMaxLatency = 8'h5a;
    eeMinGrant = 8'h3c;
    memSpaceEnable = 1'b0;
    masterFrame = 1'b0;
    gntPin_n = 1'b1;
    romProbeAddr = 32'hfffc0010;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk32(ioBaseAddr_r, 32'h00000001);
    eeLoad = 1'b1;
    @(negedge clk);
    eeLoad = 1'b0;
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].be, rows[i].wd, rd);
      bus(1'b0, rows[i].a, 4'hf, 32'h00000000, rd);
      chk32(rd, rows[i].ex);
    end
    chk32(cacheLineWords_r, 8'h08);
    chk32(memBaseAddr_r, 32'hfffffc00);
    chk32(ioBaseAddr_r, 32'hffffff01);
    // limit 3, grant withdrawn long before the frame
    masterFrame = 1'b1;
    repeat (3) @(negedge clk);
    chk1(masterStop_r, 1'b0);
    @(negedge clk);
    chk1(masterStop_r, 1'b1);
    // grant back: two sync flops delay the release
    gntPin_n = 1'b0;
    repeat (2) @(negedge clk);
    chk1(masterStop_r, 1'b1);
    @(negedge clk);
    chk1(masterStop_r, 1'b0);
    gntPin_n = 1'b1;
    repeat (3) @(negedge clk);
    chk1(masterStop_r, 1'b1);
    masterFrame = 1'b0;
    memSpaceEnable = 1'b1;
    repeat (2) @(negedge clk);
    chk1(romDecodeEn_r, 1'b1);
    chk1(romHit_r, 1'b1);
    romProbeAddr = 32'hfff80010;
    repeat (2) @(negedge clk);
    chk1(romHit_r, 1'b0);
    memSpaceEnable = 1'b0;
    romProbeAddr = 32'hfffc0010;
    repeat (2) @(negedge clk);
    chk1(romDecodeEn_r, 1'b0);
    chk1(romHit_r, 1'b0);
    // second reset in mid-run
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk32(cacheLineWords_r, 8'h00);
    chk32(memBaseAddr_r, 32'h00000000);
    bus(1'b0, 8'h3c, 4'hf, 32'h00000000, rd);
    chk32(rd, 32'h00000100);
    bus(1'b0, 8'h2c, 4'hf, 32'h00000000, rd);
    chk32(rd, 32'h00000000);
    bus(1'b0, 8'h30, 4'hf, 32'h00000000, rd);
    chk32(rd, 32'h00000000);
    close_out();
  end
endmodule : pci_config_header_regs_test
`default_nettype wire
